//--- verilog/uhpc_pkg.sv
`default_nettype none
package uhpc_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int SUPPLY_SETTLE_NS = 1000;
   localparam int SUPPLY_SETTLE_CYC =
      (SUPPLY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOCK_EDGES_DEF = 32;
   localparam int STALL_CYC_DEF = 64;

   // ****************************************************************
   // Clock figures in kHz
   // ****************************************************************
   localparam logic [15:0] KHZ_ULPI = 16'hea60;
   localparam logic [18:0] KHZ_PLL_OUT = 19'h75300;
   localparam logic [15:0] KHZ_52000 = 16'hcb20;
   localparam logic [15:0] KHZ_38400 = 16'h9600;
   localparam logic [15:0] KHZ_12000 = 16'h2ee0;
   localparam logic [15:0] KHZ_27000 = 16'h6978;
   localparam logic [15:0] KHZ_13000 = 16'h32c8;
   localparam logic [15:0] KHZ_19200 = 16'h4b00;
   localparam logic [15:0] KHZ_26000 = 16'h6590;
   localparam logic [15:0] KHZ_24000 = 16'h5dc0;

   localparam logic [2:0] SEL_52000 = 3'h0;
   localparam logic [2:0] SEL_38400 = 3'h1;
   localparam logic [2:0] SEL_12000 = 3'h2;
   localparam logic [2:0] SEL_27000 = 3'h3;
   localparam logic [2:0] SEL_13000 = 3'h4;
   localparam logic [2:0] SEL_19200 = 3'h5;
   localparam logic [2:0] SEL_26000 = 3'h6;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_REF_KHZ = 8'h08;
   localparam logic [7:0] ADDR_LOCK_LOSS = 8'h0c;
   localparam int CTRL_W = 3;
   localparam int CTRL_LOW_POWER = 0;
   localparam int CTRL_CARKIT = 1;
   localparam int CTRL_HOST_WAKE = 2;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic {
      UHPC_LINK_SOURCED,
      UHPC_PHY_SOURCED
   } uhpc_clk_mode_t;

   typedef enum logic [2:0] {
      ST_RESET,
      ST_STRAP,
      ST_SETTLE,
      ST_LOCK,
      ST_STP_WAIT,
      ST_RUN,
      ST_LOW_POWER
   } uhpc_state_t;

   typedef struct packed {
      logic hard_reset_n;
      logic low_power;
      logic dir;
      logic locked;
      logic [2:0] ref_sel;
      logic phy_mode;
   } uhpc_status_t;

   function automatic logic [15:0] uhpc_ref_khz(input logic [2:0] sel);
      logic [15:0] k;
      k = KHZ_24000;
      if (sel == SEL_52000) k = KHZ_52000;
      else if (sel == SEL_38400) k = KHZ_38400;
      else if (sel == SEL_12000) k = KHZ_12000;
      else if (sel == SEL_27000) k = KHZ_27000;
      else if (sel == SEL_13000) k = KHZ_13000;
      else if (sel == SEL_19200) k = KHZ_19200;
      else if (sel == SEL_26000) k = KHZ_26000;
      return k;
   endfunction : uhpc_ref_khz

endpackage : uhpc_pkg
`default_nettype wire

//--- verilog/uhpc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module uhpc_sync
   import uhpc_pkg::*;
#(
   parameter int W = 1
)
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q,
   output logic [W-1:0] rise
);

   // ****************************************************************
   // Two-stage synchroniser and edge finder
   // ****************************************************************
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [W-1:0] prev_q;

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end
      else
      begin
         meta_q <= d;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign q = sync_q;
   assign rise = sync_q & ~prev_q;

endmodule : uhpc_sync
`default_nettype wire

//--- verilog/uhpc_pll_reference_in_ctrl.sv
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// - Two clock modes: link sources 60 MHz, or device makes 60 MHz.
// - Clock output pin high at start-up selects link-sourced 60 MHz mode.
// - Link-sourced mode: DIR drops only after lock; link waits for it.
// - Device-sourced mode: after lock, drive 60 MHz out and drop DIR.
// - Generated clock stays within 500 ppm of nominal.
// - No phase alignment needed between reference and generated clock.
// - Three-bit strap picks reference frequency from eight fixed values.
// - Only rising reference edges matter; falling edges ignored.
// - PLL multiplies reference to 480 MHz for transmit and receive.
// - Reference starting late after reset release delays start equally.
// - Running reference while hard reset low never starts the device.
// - Device leaves low power when link raises STP.
// - Reference loss in synchronous mode drops lock; session may drop.
// - After supplies settle, DIR stays high until PLL locks.
// - STP held high at start-up keeps DIR high until it falls.
module uhpc_pll_reference_in_ctrl
   import uhpc_pkg::*;
#(
   parameter int LOCK_EDGES = LOCK_EDGES_DEF,
   parameter int STALL_CYC = STALL_CYC_DEF
)
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic hard_reset_n,
   input wire logic pll_reference_in,
   input wire logic ulpi_clock_output_strap_i,
   output logic ulpi_clock_output_strap_o,
   output logic ulpi_clock_output_strap_oe,
   input wire logic [2:0] ref_freq_select_straps,
   input wire logic stp,
   output logic dir_o,
   output logic dir_oe,
   output logic pll_run,
   output logic pll_locked,
   output logic [15:0] pll_ref_khz,
   output logic [18:0] pll_out_khz,
   output logic host_wake_resume_en
);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [6:0] pin_q;
   logic [6:0] pin_rise;
   wire hrn_s;
   wire ref_rise;
   wire strap_s;
   wire stp_s;
   wire [2:0] sel_s;

   uhpc_sync #(.W(7)) u_sync (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .d({ref_freq_select_straps, stp, ulpi_clock_output_strap_i,
          pll_reference_in, hard_reset_n}),
      .q(pin_q),
      .rise(pin_rise)
   );

   assign hrn_s = pin_q[0];
   assign ref_rise = pin_rise[1];
   assign strap_s = pin_q[2];
   assign stp_s = pin_q[3];
   assign sel_s = pin_q[6:4];

   // ****************************************************************
   // State and counters
   // ****************************************************************
   uhpc_state_t state_q;
   uhpc_state_t state_d;
   uhpc_clk_mode_t mode_q;
   logic [2:0] ref_sel_q;
   logic [15:0] settle_q;
   logic [15:0] gap_q;
   logic [15:0] edges_q;
   logic [15:0] lock_loss_q;
   logic [CTRL_W-1:0] ctrl_q;
   logic [31:0] prdata_q;

   wire stall;
   wire settled;
   wire lock_done;
   wire locked;
   wire lp_req;
   wire lose_lock;

   // Missing reference edges mean lock is gone
   assign stall = (gap_q >= 16'(STALL_CYC - 1));
   assign settled = (settle_q >= 16'(SUPPLY_SETTLE_CYC - 1));
   // Lock waits for edges, so a late reference delays start
   assign lock_done = (edges_q >= 16'(LOCK_EDGES - 1)) && ref_rise;
   assign locked = (state_q == ST_STP_WAIT) || (state_q == ST_RUN);
   assign lp_req = ctrl_q[CTRL_LOW_POWER] | ctrl_q[CTRL_CARKIT];
   assign lose_lock = locked && stall;

   // ****************************************************************
   // Start-up and lock sequencer
   // ****************************************************************
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_RESET:
            if (hrn_s)
               state_d = ST_STRAP;
         ST_STRAP:
            state_d = ST_SETTLE;
         ST_SETTLE:
            if (settled)
               state_d = ST_LOCK;
         ST_LOCK:
            if (lock_done)
               state_d = ST_STP_WAIT;
         ST_STP_WAIT:
            if (stall)
               state_d = ST_LOCK;
            else if (!stp_s)
               state_d = ST_RUN;
         ST_RUN:
            if (stall)
               state_d = ST_LOCK;
            else if (lp_req)
               state_d = ST_LOW_POWER;
         ST_LOW_POWER:
            if (stp_s)
               state_d = ST_LOCK;
         default:
            state_d = ST_RESET;
      endcase
      // Reference ignored while hard reset is low
      if (!hrn_s)
         state_d = ST_RESET;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         state_q <= ST_RESET;
      else
         state_q <= state_d;
   end

   // ****************************************************************
   // Strap capture
   // ****************************************************************
   // Straps latched once per reset
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         mode_q <= UHPC_PHY_SOURCED;
         ref_sel_q <= '0;
      end
      else if (state_q == ST_STRAP)
      begin
         mode_q <= strap_s ? UHPC_LINK_SOURCED : UHPC_PHY_SOURCED;
         ref_sel_q <= sel_s;
      end
   end

   // ****************************************************************
   // Supply settle, edge gap and lock counters
   // ****************************************************************
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || state_q != ST_SETTLE)
         settle_q <= '0;
      else if (!settled)
         settle_q <= settle_q + 16'h0001;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || ref_rise || state_q == ST_RESET)
         gap_q <= '0;
      else if (!stall)
         gap_q <= gap_q + 16'h0001;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || state_q != ST_LOCK || stall)
         edges_q <= '0;
      else if (ref_rise)
         edges_q <= edges_q + 16'h0001;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         lock_loss_q <= '0;
      else if (lose_lock && lock_loss_q != 16'hffff)
         lock_loss_q <= lock_loss_q + 16'h0001;
   end

   // ****************************************************************
   // Pin and PLL controls
   // ****************************************************************
   logic dir_q;
   logic dir_oe_q;
   logic clk_gate_q;

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         dir_q <= 1'b1;
         dir_oe_q <= 1'b0;
         clk_gate_q <= 1'b0;
      end
      else
      begin
         // DIR falls only once locked and STP low
         dir_q <= (state_d != ST_RUN);
         dir_oe_q <= (state_d != ST_RESET) && (state_d != ST_STRAP);
         // Gate opens without any phase alignment
         clk_gate_q <= (mode_q == UHPC_PHY_SOURCED) &&
                       ((state_d == ST_STP_WAIT) || (state_d == ST_RUN));
      end
   end

   assign dir_o = dir_q;
   assign dir_oe = dir_oe_q;
   // Link-sourced mode never drives the strap pin
   assign ulpi_clock_output_strap_o = clk_gate_q;
   assign ulpi_clock_output_strap_oe = clk_gate_q;
   assign pll_run = (state_q == ST_LOCK) || locked;
   assign pll_locked = locked;
   // Reference is 60 MHz in link mode, else strap choice
   assign pll_ref_khz = (mode_q == UHPC_LINK_SOURCED) ? KHZ_ULPI :
                        uhpc_ref_khz(ref_sel_q);
   // Generated clock figure is fixed at the 480 MHz PLL output rate
   assign pll_out_khz = KHZ_PLL_OUT;
   assign host_wake_resume_en = ctrl_q[CTRL_HOST_WAKE];

   // ****************************************************************
   // APB slave
   // ****************************************************************
   wire setup;
   wire access;
   wire hit_ctrl;
   wire hit_status;
   wire hit_ref;
   wire hit_loss;
   wire hit_any;
   wire wr_ctrl;
   uhpc_status_t status;

   assign setup = psel && !penable;
   assign access = psel && penable;
   assign hit_ctrl = (paddr == ADDR_CTRL);
   assign hit_status = (paddr == ADDR_STATUS);
   assign hit_ref = (paddr == ADDR_REF_KHZ);
   assign hit_loss = (paddr == ADDR_LOCK_LOSS);
   assign hit_any = hit_ctrl | hit_status | hit_ref | hit_loss;
   assign wr_ctrl = access && pwrite && hit_ctrl;
   assign pready = 1'b1;
   assign pslverr = access && !hit_any;

   assign status.hard_reset_n = hrn_s;
   assign status.low_power = (state_q == ST_LOW_POWER);
   assign status.dir = dir_q;
   assign status.locked = locked;
   assign status.ref_sel = ref_sel_q;
   assign status.phy_mode = (mode_q == UHPC_PHY_SOURCED);

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || !hrn_s)
         ctrl_q <= CTRL_RESET;
      else if (wr_ctrl)
         ctrl_q <= pwdata[CTRL_W-1:0];
      else if (state_q == ST_LOW_POWER && stp_s)
      begin
         ctrl_q[CTRL_LOW_POWER] <= 1'b0;
         ctrl_q[CTRL_CARKIT] <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         prdata_q <= '0;
      else if (setup)
      begin
         if (pwrite)
            prdata_q <= '0;
         else if (hit_ctrl)
            prdata_q <= {{(32-CTRL_W){1'b0}}, ctrl_q};
         else if (hit_status)
            prdata_q <= {24'h000000, status};
         else if (hit_ref)
            prdata_q <= {16'h0000, pll_ref_khz};
         else if (hit_loss)
            prdata_q <= {16'h0000, lock_loss_q};
         else
            prdata_q <= '0;
      end
   end

   assign prdata = prdata_q;

endmodule : uhpc_pll_reference_in_ctrl
`default_nettype wire

//--- verif/uhpc_pll_reference_in_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Checker
// ****
module uhpc_pll_reference_in_ctrl_chk
   import uhpc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic hard_reset_n,
   input wire logic stp,
   input wire logic dir_o,
   input wire logic pll_run,
   input wire logic pll_locked,
   input wire logic [15:0] pll_ref_khz,
   input wire logic [18:0] pll_out_khz,
   input wire logic ulpi_clock_output_strap_oe
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   sequence s_stp_held;
      stp [*6];
   endsequence
   sequence s_hrn_low;
      !hard_reset_n [*4];
   endsequence
   a_dir_after_lock:
      assert property ($fell(dir_o) |-> $past(pll_locked))
      else $error("dir fell before lock");
   a_stp_keeps_dir:
      assert property (s_stp_held |=> !$fell(dir_o))
      else $error("dir fell while stp high");
   a_reset_blocks_start:
      assert property (s_hrn_low |=> dir_o && !pll_run)
      else $error("started under hard reset");
   a_ulpi_clock_output_strap_after_lock:
      assert property ($rose(ulpi_clock_output_strap_oe) |-> pll_locked)
      else $error("clock out before lock");
   a_ulpi_clock_output_strap_phy_only:
      assert property (ulpi_clock_output_strap_oe |->
         pll_ref_khz != KHZ_ULPI)
      else $error("clock out in link mode");
   a_pll_out_rate:
      assert property (pll_run |-> pll_out_khz == KHZ_PLL_OUT)
      else $error("pll output rate wrong");
   a_strap_held:
      assert property (pll_locked && $past(pll_locked) |->
         $stable(pll_ref_khz))
      else $error("strap value moved");
   a_dir_while_locking:
      assert property (pll_run && !pll_locked &&
         $past(pll_run && !pll_locked) |-> dir_o)
      else $error("dir low while locking");
endmodule : uhpc_pll_reference_in_ctrl_chk
bind uhpc_pll_reference_in_ctrl uhpc_pll_reference_in_ctrl_chk chk_u (
   .clk_sys(clk_sys),
   .sys_rst(sys_rst),
   .hard_reset_n(hard_reset_n),
   .stp(stp),
   .dir_o(dir_o),
   .pll_run(pll_run),
   .pll_locked(pll_locked),
   .pll_ref_khz(pll_ref_khz),
   .pll_out_khz(pll_out_khz),
   .ulpi_clock_output_strap_oe(ulpi_clock_output_strap_oe)
);
`default_nettype wire

//--- verif/uhpc_link_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Link reference clock
// ****
module uhpc_link_model (
   input wire logic ref_en,
   output logic pll_reference_in,
   output logic [7:0] idle_data
);
   // Data bus idle for the link
   assign idle_data = 8'h00;
   initial
   begin
      pll_reference_in = 1'b0;
      #1.7;
      forever #80 pll_reference_in = ref_en ? ~pll_reference_in : 1'b0;
   end
endmodule : uhpc_link_model
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module tb
   import uhpc_pkg::*;
;
   localparam logic [15:0] TAB [8] = '{KHZ_52000, KHZ_38400, KHZ_12000,
      KHZ_27000, KHZ_13000, KHZ_19200, KHZ_26000, KHZ_24000};
   logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, hrn = 0, ref_en = 0, stp = 1, tie = 1;
   logic ref_clk, s_o, s_oe, dir_o, dir_oe, pll_run, pll_locked, hwre;
   logic [2:0] sel = 3'h0;
   logic [15:0] khz;
   logic [18:0] okhz;
   logic [7:0] udata;
   int mismatches = 0, n_tests = 0;
   wire strap = s_oe ? s_o : tie;
   always #4 clk_sys = ~clk_sys;
   uhpc_link_model link_u (.ref_en(ref_en), .pll_reference_in(ref_clk),
      .idle_data(udata));
   uhpc_pll_reference_in_ctrl #(.LOCK_EDGES(4), .STALL_CYC(64)) dut_u (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .hard_reset_n(hrn), .pll_reference_in(ref_clk),
      .ulpi_clock_output_strap_i(strap), .ulpi_clock_output_strap_o(s_o),
      .ulpi_clock_output_strap_oe(s_oe), .ref_freq_select_straps(sel),
      .stp(stp), .dir_o(dir_o), .dir_oe(dir_oe), .pll_run(pll_run),
      .pll_locked(pll_locked), .pll_ref_khz(khz), .pll_out_khz(okhz),
      .host_wake_resume_en(hwre));
   task automatic report_and_stop;
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1)
      begin
         mismatches++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   task automatic wait_for(ref logic s, input logic v, input string m);
      int k;
      k = 0;
      while (s !== v && k < 400)
      begin
         @(posedge clk_sys);
         k++;
      end
      chk(s === v, m);
   endtask : wait_for
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      @(posedge clk_sys);
      while (pready !== 1'b1 && k < 20)
      begin
         @(posedge clk_sys);
         k++;
      end
      chk(pready === 1'b1, "apb no ready");
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk_sys);
   endtask : apb
   task automatic boot(input logic m, input logic [2:0] s, input logic late);
      hrn <= 0;
      stp <= 1;
      // Strap pin held high in link mode
      tie <= m;
      sel <= s;
      ref_en <= 1;
      cyc(40);
      chk(pll_run === 1'b0 && dir_o === 1'b1 && dir_oe === 1'b0,
         "ran in reset");
      ref_en <= !late;
      hrn <= 1;
      if (late)
      begin
         cyc(300);
         chk(pll_locked === 1'b0, "locked with no ref");
         ref_en <= 1;
      end
      wait_for(pll_locked, 1'b1, "no lock");
      cyc(10);
      chk(dir_o === 1'b1, "dir fell with stp high");
      chk(dir_oe === 1'b1, "dir not driven");
      stp <= 0;
      wait_for(dir_o, 1'b0, "dir never fell");
      chk(khz === (m ? KHZ_ULPI : TAB[s]), "ref rate");
      chk(s_oe === !m && s_o === !m, "clock out enable");
      chk(udata === 8'h00, "bus not idle");
   endtask : boot
   task automatic t_hold;
      sel <= 3'h2;
      cyc(10);
      chk(khz === KHZ_24000 && s_oe === 1'b1, "strap moved");
      chk(okhz === KHZ_PLL_OUT, "pll rate");
   endtask : t_hold
   task automatic t_stall;
      ref_en <= 0;
      wait_for(dir_o, 1'b1, "no stall");
      chk(pll_locked === 1'b0, "lock kept");
      apb(0, ADDR_LOCK_LOSS, 32'h0);
      chk(rd === 32'h1 && er === 1'b0, "loss count");
      ref_en <= 1;
      wait_for(dir_o, 1'b0, "no relock");
   endtask : t_stall
   task automatic t_low_power;
      apb(1, ADDR_CTRL, 32'h1);
      cyc(3);
      chk(dir_o === 1'b1 && pll_run === 1'b0, "no low power");
      ref_en <= 0;
      cyc(100);
      chk(dir_o === 1'b1 && pll_run === 1'b0, "left low power");
      stp <= 1;
      ref_en <= 1;
      wait_for(pll_run, 1'b1, "no wake");
      apb(0, ADDR_CTRL, 32'h0);
      chk(rd === 32'h0, "ctrl not cleared");
      stp <= 0;
      wait_for(dir_o, 1'b0, "dir after wake");
   endtask : t_low_power
   task automatic t_regs;
      apb(1, ADDR_CTRL, 32'h4);
      chk(hwre === 1'b1, "host wake");
      apb(0, ADDR_CTRL, 32'h0);
      chk(rd === 32'h4, "ctrl read");
      apb(0, ADDR_REF_KHZ, 32'h0);
      chk(rd === {16'h0, KHZ_24000}, "rate read");
      apb(0, ADDR_STATUS, 32'h0);
      chk(rd === 32'h9f && er === 1'b0, "status read");
      apb(0, 8'h40, 32'h0);
      chk(er === 1'b1 && rd === 32'h0, "unmapped");
   endtask : t_regs
   initial
   begin
      #200us;
      mismatches++;
      report_and_stop;
   end
   initial
   begin
      cyc(10);
      sys_rst <= 0;
      boot(1, 3'h5, 1);
      for (int i = 0; i < 8; i++)
         boot(0, i[2:0], 0);
      t_hold;
      t_stall;
      t_low_power;
      t_regs;
      report_and_stop;
   end
endmodule : tb
`default_nettype wire
